//--- rtl/serial_port_config_and_paging_regs.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_config_and_paging_regs
    import cfg_regs_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [11:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] i_ch0_rdata,
    input wire logic [7:0] i_ch1_rdata,
    input wire logic [7:0] i_com_rdata,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic [11:0] o_next_addr,
    output logic o_bit_order_select,
    output logic o_address_step_direction,
    output logic o_serial_out_enable,
    output logic o_soft_reset,
    output logic [1:0] o_ch_wr,
    output logic o_com_wr,
    output logic [11:0] o_wr_addr,
    output logic [7:0] o_wr_data
);

    typedef struct packed {
        cfg_state_t st;
        logic [3:0] cnt;
        logic srst_bit;
        logic order;
        logic step;
        logic sdo;
        logic [1:0] page;
        logic [7:0] rdata;
        logic rvalid;
        logic [11:0] next_addr;
        logic [1:0] ch_wr;
        logic com_wr;
        logic [11:0] wr_addr;
        logic [7:0] wr_data;
    } regs_t;

    regs_t r_r;
    regs_t r_nxt;

    // address falls in one of the paged ranges
    function automatic logic is_paged(input logic [11:0] a);
        is_paged = (a >= PAGED_A_LO && a <= PAGED_A_HI) || (a >= PAGED_B_LO && a <= PAGED_B_HI) ||
                   (a >= PAGED_C_LO && a <= PAGED_C_HI) || (a >= PAGED_D_LO && a <= PAGED_D_HI);
    endfunction

    // address is held in this bank
    function automatic logic is_local(input logic [11:0] a);
        is_local = (a == ADDR_INTF_CFG) || (a == ADDR_PROD_TYPE) || (a == ADDR_PROD_ID_LO) ||
                   (a == ADDR_PROD_ID_HI) || (a == ADDR_GRADE_REV) || (a == ADDR_PAGE_SEL);
    endfunction

    // channel write enables from the page field
    function automatic logic [1:0] page_wr(input logic [1:0] pg);
        unique case (pg)
            PAGE_CH0: page_wr = 2'h1; // RQ10
            PAGE_CH1: page_wr = 2'h2; // RQ10
            PAGE_BOTH: page_wr = 2'h3; // RQ7
            default: page_wr = 2'h0;
        endcase
    endfunction

    // next state
    always_comb begin
        r_nxt = r_r;
        r_nxt.rvalid = 1'b0;
        r_nxt.ch_wr = 2'h0;
        r_nxt.com_wr = 1'b0;
        // multibyte address stepping
        if (i_wr || i_rd) begin
            if (r_r.step) begin
                r_nxt.next_addr = i_addr + 12'h001; // RQ2
            end else begin
                r_nxt.next_addr = i_addr - 12'h001; // RQ3
            end
        end
        // read mux
        if (i_rd) begin
            r_nxt.rvalid = 1'b1;
            if (is_paged(i_addr)) begin
                r_nxt.rdata = (r_r.page == PAGE_CH1) ? i_ch1_rdata : i_ch0_rdata; // RQ7 RQ10
            end else begin
                unique case (i_addr)
                    ADDR_INTF_CFG: r_nxt.rdata = {r_r.srst_bit, r_r.order, r_r.step, r_r.sdo,
                                                  r_r.sdo, r_r.step, r_r.order, r_r.srst_bit}; // RQ9
                    ADDR_PROD_TYPE: r_nxt.rdata = PRODUCT_CLASS_CODE; // RQ5
                    ADDR_PROD_ID_LO: r_nxt.rdata = PART_ID_LOW_BYTE;
                    ADDR_PROD_ID_HI: r_nxt.rdata = PART_ID_HIGH_BYTE;
                    ADDR_GRADE_REV: r_nxt.rdata = {PART_GRADE_FIELD, SILICON_REVISION_FIELD};
                    ADDR_PAGE_SEL: r_nxt.rdata = {6'h00, r_r.page}; // RQ6
                    default: r_nxt.rdata = i_com_rdata; // RQ8
                endcase
            end
        end
        // external write routing
        if (i_wr && !is_local(i_addr)) begin
            r_nxt.wr_addr = i_addr;
            r_nxt.wr_data = i_wdata;
            if (is_paged(i_addr)) begin
                r_nxt.ch_wr = page_wr(r_r.page); // RQ6
            end else begin
                r_nxt.com_wr = 1'b1; // RQ8
            end
        end
        // local writes and soft reset sequence
        unique case (r_r.st)
            ST_IDLE: begin
                if (i_wr && i_addr == ADDR_INTF_CFG) begin
                    r_nxt.order = i_wdata[ORDER_BIT]; // RQ4
                    r_nxt.step = i_wdata[STEP_BIT];
                    r_nxt.sdo = i_wdata[SDO_BIT];
                    if (i_wdata[SRST_BIT]) begin
                        r_nxt.srst_bit = 1'b1; // RQ1
                        r_nxt.cnt = SOFT_RST_CYCLES;
                        r_nxt.st = ST_SRST;
                    end
                end
                if (i_wr && i_addr == ADDR_PAGE_SEL) begin
                    r_nxt.page = i_wdata[1:0]; // RQ6
                end
            end
            ST_SRST: begin
                // local writes ignored until the soft reset ends
                r_nxt.cnt = r_r.cnt - 4'h1;
                if (r_r.cnt == 4'h1) begin
                    r_nxt.srst_bit = 1'b0; // RQ1
                    r_nxt.order = INTF_BIT_RST;
                    r_nxt.step = INTF_BIT_RST;
                    r_nxt.sdo = INTF_BIT_RST;
                    r_nxt.page = PAGE_RST;
                    r_nxt.st = ST_IDLE;
                end
            end
        endcase
    end

    // state register, frozen while clock enable is low
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            r_r <= '{st: ST_IDLE, cnt: 4'h0, srst_bit: 1'b0, order: INTF_BIT_RST, step: INTF_BIT_RST,
                     sdo: INTF_BIT_RST, page: PAGE_RST, rdata: 8'h00, rvalid: 1'b0,
                     next_addr: 12'h000, ch_wr: 2'h0, com_wr: 1'b0, wr_addr: 12'h000, wr_data: 8'h00};
        end else if (i_ce) begin
            r_r <= r_nxt;
        end
    end

    // outputs straight from the state register
    assign o_rdata = r_r.rdata;
    assign o_rvalid = r_r.rvalid;
    assign o_next_addr = r_r.next_addr;
    assign o_bit_order_select = r_r.order; // RQ4
    assign o_address_step_direction = r_r.step;
    assign o_serial_out_enable = r_r.sdo;
    assign o_soft_reset = r_r.srst_bit;
    assign o_ch_wr = r_r.ch_wr;
    assign o_com_wr = r_r.com_wr;
    assign o_wr_addr = r_r.wr_addr;
    assign o_wr_data = r_r.wr_data;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence srst_req_s;
        i_ce && i_wr && i_addr == ADDR_INTF_CFG && i_wdata[SRST_BIT] && !o_soft_reset;
    endsequence

    sequence srst_run_s;
        o_soft_reset [*4];
    endsequence

    srst_start_a: assert property (srst_req_s |=> srst_run_s) // RQ1
        else $error("soft reset did not hold for its duration");
    srst_clear_a: assert property ($rose(o_soft_reset) |-> ##[4:1000] !o_soft_reset) // RQ1
        else $error("soft reset bit did not clear");
    addr_inc_a: assert property (i_ce && (i_wr || i_rd) && o_address_step_direction // RQ2
        |=> o_next_addr == $past(i_addr) + 12'h001)
        else $error("address did not step up");
    addr_dec_a: assert property (i_ce && (i_wr || i_rd) && !o_address_step_direction // RQ3
        |=> o_next_addr == $past(i_addr) - 12'h001)
        else $error("address did not step down");
    bit_order_a: assert property (i_ce && i_wr && i_addr == ADDR_INTF_CFG && !o_soft_reset // RQ4
        |=> o_bit_order_select == $past(i_wdata[ORDER_BIT]))
        else $error("bit order not taken from write");
    type_read_a: assert property (i_ce && i_rd && i_addr == ADDR_PROD_TYPE // RQ5
        |=> o_rvalid && o_rdata == PRODUCT_CLASS_CODE)
        else $error("product type read wrong");
    page_read_a: assert property (i_ce && i_rd && i_addr == ADDR_PAGE_SEL // RQ6
        |=> o_rdata == {6'h00, $past(r_r.page)})
        else $error("page read wrong");
    both_write_a: assert property (i_ce && i_wr && is_paged(i_addr) && r_r.page == PAGE_BOTH // RQ7
        |=> o_ch_wr == 2'h3 && !o_com_wr)
        else $error("page three did not write both channels");
    unpaged_wr_a: assert property (i_ce && i_wr && !is_local(i_addr) && !is_paged(i_addr) // RQ8
        |=> o_com_wr && o_ch_wr == 2'h0)
        else $error("unpaged write followed the page");
    mirror_read_a: assert property (i_ce && i_rd && i_addr == ADDR_INTF_CFG // RQ9
        |=> o_rdata[7:4] == {o_rdata[0], o_rdata[1], o_rdata[2], o_rdata[3]})
        else $error("mirror bits do not match");
    single_page_a: assert property (i_ce && i_wr && is_paged(i_addr) && r_r.page == PAGE_CH1 // RQ10
        |=> o_ch_wr == 2'h2)
        else $error("page two did not select channel one only");
    // page one must reach channel zero alone
    ch0_only_a: assert property (i_ce && i_wr && is_paged(i_addr) && r_r.page == PAGE_CH0 // RQ10
        |=> o_ch_wr == 2'h1 && !o_com_wr)
        else $error("page one did not select channel zero only");
    // page zero writes no channel and never leaks to the common bank
    page_zero_a: assert property (i_ce && i_wr && is_paged(i_addr) && r_r.page == 2'h0 // RQ6
        |=> o_ch_wr == 2'h0 && !o_com_wr)
        else $error("page zero wrote a channel");
    // low nibble of the config read is the live control bits
    mirror_low_a: assert property (i_ce && i_rd && i_addr == ADDR_INTF_CFG // RQ9
        |=> o_rdata[3:0] == {$past(o_serial_out_enable), $past(o_address_step_direction),
                             $past(o_bit_order_select), $past(o_soft_reset)})
        else $error("config read does not match its control bits");
    // end of soft reset leaves the controls at their reset values
    srst_restore_a: assert property ($fell(o_soft_reset) // RQ1
        |-> !o_bit_order_select && !o_address_step_direction && !o_serial_out_enable && r_r.page == PAGE_RST)
        else $error("soft reset did not restore the controls");

endmodule
`default_nettype wire

//--- rtl/cfg_regs_pkg.sv
// Behaviour
// (RQ1) Writing 1 to bit 0 of the interface configuration register starts a soft reset, and the bit clears itself when that reset is done.
// (RQ2) With the address-step bit (bit 2) at 1 the register address goes up by one after each byte of a multibyte transfer.
// (RQ3) With the address-step bit at 0, its reset value, the register address goes down by one after each byte of a multibyte transfer.
// (RQ4) The bit-order bit (bit 1) sets the order of incoming and outgoing serial data, 1 for least significant bit first and 0 for most significant first.
// (RQ5) A read-only 8-bit product type register holds a fixed code that marks the part as a high-speed converter.
// (RQ6) A 2-bit channel page field, reset to 3, chooses which channel's per-channel feature registers reads and writes reach.
// (RQ7) With the page field at 3, writes to paged registers reach both channels and reads return channel 0.
// (RQ8) Paging applies only to 0x013-0x014, 0x034-0x03d, 0x110-0x124 and 0x135-0x14c; every other address ignores the page field.
// (RQ9) Bits 7 to 4 of the interface configuration register are read-only copies of bits 0 to 3, and writes to them are ignored.
// (RQ10) Page value 1 routes paged reads and writes to channel 0 only, and page value 2 routes them to channel 1 only.
package cfg_regs_pkg;

    // register offsets
    localparam logic [11:0] ADDR_INTF_CFG = 12'h000;
    localparam logic [11:0] ADDR_PROD_TYPE = 12'h003;
    localparam logic [11:0] ADDR_PROD_ID_LO = 12'h004;
    localparam logic [11:0] ADDR_PROD_ID_HI = 12'h005;
    localparam logic [11:0] ADDR_GRADE_REV = 12'h006;
    localparam logic [11:0] ADDR_PAGE_SEL = 12'h008;

    // paged address ranges
    localparam logic [11:0] PAGED_A_LO = 12'h013;
    localparam logic [11:0] PAGED_A_HI = 12'h014;
    localparam logic [11:0] PAGED_B_LO = 12'h034;
    localparam logic [11:0] PAGED_B_HI = 12'h03d;
    localparam logic [11:0] PAGED_C_LO = 12'h110;
    localparam logic [11:0] PAGED_C_HI = 12'h124;
    localparam logic [11:0] PAGED_D_LO = 12'h135;
    localparam logic [11:0] PAGED_D_HI = 12'h14c;

    // interface configuration field positions
    localparam int SRST_BIT = 0;
    localparam int ORDER_BIT = 1;
    localparam int STEP_BIT = 2;
    localparam int SDO_BIT = 3;

    // reset values
    localparam logic INTF_BIT_RST = 1'b0;
    localparam logic [1:0] PAGE_RST = 2'h3;

    // page encodings
    localparam logic [1:0] PAGE_CH0 = 2'h1;
    localparam logic [1:0] PAGE_CH1 = 2'h2;
    localparam logic [1:0] PAGE_BOTH = 2'h3;

    // identity codes, values are arbitrary
    localparam logic [7:0] PRODUCT_CLASS_CODE = 8'h0a;
    localparam logic [7:0] PART_ID_LOW_BYTE = 8'h3c;
    localparam logic [7:0] PART_ID_HIGH_BYTE = 8'h7e;
    localparam logic [3:0] PART_GRADE_FIELD = 4'h2;
    localparam logic [3:0] SILICON_REVISION_FIELD = 4'h1;

    // soft reset duration
    localparam int CLK_MHZ = 20;
    localparam int SOFT_RST_NS = 200;
    localparam logic [3:0] SOFT_RST_CYCLES = 4'((SOFT_RST_NS * CLK_MHZ + 999) / 1000);

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_SRST = 1'b1
    } cfg_state_t;

endpackage

//--- tb/channel_regs_model.sv
`timescale 1ns/1ps
`default_nettype none
module channel_regs_model (
    input wire logic i_mclk,
    input wire logic [11:0] i_addr,
    input wire logic [1:0] i_ch_wr,
    input wire logic i_com_wr,
    input wire logic [11:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    output logic [7:0] o_ch0_rdata,
    output logic [7:0] o_ch1_rdata,
    output logic [7:0] o_com_rdata
);
    logic [7:0] ch0_r [16];
    logic [7:0] ch1_r [16];
    logic [7:0] com_r [16];
    // each write pulse lands only in the bank it names
    always_ff @(posedge i_mclk) begin
        if (i_ch_wr[0]) begin
            ch0_r[i_wr_addr[3:0]] <= i_wr_data;
        end
        if (i_ch_wr[1]) begin
            ch1_r[i_wr_addr[3:0]] <= i_wr_data;
        end
        if (i_com_wr) begin
            com_r[i_wr_addr[3:0]] <= i_wr_data;
        end
    end
    // addressed contents answer in the same cycle as the read strobe
    assign o_ch0_rdata = ch0_r[i_addr[3:0]];
    assign o_ch1_rdata = ch1_r[i_addr[3:0]];
    assign o_com_rdata = com_r[i_addr[3:0]];
endmodule
`default_nettype wire

//--- tb/serial_port_config_and_paging_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_config_and_paging_regs_bench;
    import cfg_regs_pkg::*;
    logic mclk, rst, ce, wr, rd, rvalid, ord, stp, sdo, srst, com_wr;
    logic [11:0] addr, nxt, wa;
    logic [7:0] wdata, ch0, ch1, com, rdata, wd, q;
    logic [1:0] ch_wr;
    int errors, total_checks, n;
    logic [11:0] pl [16] = '{12'h013, 12'h014, 12'h034, 12'h03d, 12'h110, 12'h124, 12'h135, 12'h14c,
        12'h012, 12'h015, 12'h033, 12'h03e, 12'h10f, 12'h125, 12'h134, 12'h14d};
    serial_port_config_and_paging_regs u_serial_port_config_and_paging_regs (.i_mclk(mclk), .i_rst(rst),
        .i_ce(ce), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .i_ch0_rdata(ch0), .i_ch1_rdata(ch1),
        .i_com_rdata(com), .o_rdata(rdata), .o_rvalid(rvalid), .o_next_addr(nxt), .o_bit_order_select(ord),
        .o_address_step_direction(stp), .o_serial_out_enable(sdo), .o_soft_reset(srst), .o_ch_wr(ch_wr),
        .o_com_wr(com_wr), .o_wr_addr(wa), .o_wr_data(wd));
    channel_regs_model u_channel_regs_model (.i_mclk(mclk), .i_addr(addr), .i_ch_wr(ch_wr), .i_com_wr(com_wr),
        .i_wr_addr(wa), .i_wr_data(wd), .o_ch0_rdata(ch0), .o_ch1_rdata(ch1), .o_com_rdata(com));
    // compare and count
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one byte write, strobe held for one sampled edge
    task automatic wrb(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask
    // one byte read, answer taken the cycle after the strobe
    task automatic rdb(input logic [11:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(12'(rvalid), 12'h001);
        q = rdata;
    endtask
    task automatic t_reset();
        chk(12'(stp), 12'h000);
        rdb(ADDR_PROD_TYPE);
        chk(12'(q), 12'(PRODUCT_CLASS_CODE));
        rdb(ADDR_PAGE_SEL);
        chk(12'(q), 12'h003);
        $display("reset test done");
    endtask
    task automatic t_config();
        wrb(ADDR_INTF_CFG, 8'hfe);
        chk(12'({ord, stp, sdo}), 12'h007);
        rdb(ADDR_INTF_CFG);
        chk(12'(q), 12'h07e);
        rdb(12'h010);
        chk(nxt, 12'h011);
        wrb(ADDR_INTF_CFG, 8'h00);
        rdb(12'h010);
        chk(nxt, 12'h00f);
        chk(12'(ord), 12'h000);
        $display("config test done");
    endtask
    task automatic t_srst();
        wrb(ADDR_PAGE_SEL, 8'h01);
        wrb(ADDR_INTF_CFG, 8'h0f);
        n = 1;
        chk(12'(srst), 12'h001);
        for (int i = 0; i < 10 && srst; i++) begin
            @(posedge mclk);
            #1;
            n = n + 32'(srst);
        end
        if (srst) begin
            chk(12'(srst), 12'h000);
            summarize();
        end
        chk(12'(n), 12'(SOFT_RST_CYCLES));
        rdb(ADDR_INTF_CFG);
        chk(12'(q), 12'h000);
        rdb(ADDR_PAGE_SEL);
        chk(12'(q), 12'h003);
        $display("soft reset test done");
    endtask
    task automatic t_paging();
        wrb(ADDR_PAGE_SEL, 8'h01);
        wrb(12'h013, 8'ha1);
        chk(12'(ch_wr), 12'h001);
        wrb(ADDR_PAGE_SEL, 8'h02);
        wrb(12'h013, 8'hb2);
        chk(12'(ch_wr), 12'h002);
        rdb(12'h013);
        chk(12'(q), 12'h0b2);
        wrb(ADDR_PAGE_SEL, 8'h01);
        rdb(12'h013);
        chk(12'(q), 12'h0a1);
        wrb(ADDR_PAGE_SEL, 8'h03);
        wrb(12'h013, 8'hc3);
        chk(12'(ch_wr), 12'h003);
        wrb(ADDR_PAGE_SEL, 8'h02);
        wrb(12'h013, 8'hd4);
        wrb(ADDR_PAGE_SEL, 8'h03);
        rdb(12'h013);
        chk(12'(q), 12'h0c3);
        wrb(ADDR_PAGE_SEL, 8'h00);
        wrb(12'h013, 8'he5);
        chk({9'h0, ch_wr, com_wr}, 12'h000);
        rdb(12'h013);
        chk(12'(q), 12'h0c3);
        $display("paging test done");
    endtask
    // a write while clock enable is low must leave the bit-order and step controls and the next address untouched
    task automatic t_ce();
        @(posedge mclk);
        ce <= 1'b0;
        addr <= ADDR_INTF_CFG;
        wdata <= 8'h06;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        ce <= 1'b1;
        #1;
        chk(12'({ord, stp}), 12'h000);
        chk(nxt, 12'h012);
        $display("clock enable test done");
    endtask
    // range edges just inside and just outside every paged window
    task automatic t_ranges();
        wrb(ADDR_PAGE_SEL, 8'h02);
        for (int i = 0; i < 16; i++) begin
            wrb(pl[i], 8'(i));
            chk({9'h0, ch_wr, com_wr}, (i < 8) ? 12'h004 : 12'h001);
            chk(wa, pl[i]);
        end
        $display("range test done");
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        ce = 1'b1;
        addr = 12'h000;
        wdata = 8'h00;
        errors = 0;
        total_checks = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_config();
        t_srst();
        t_paging();
        t_ce();
        t_ranges();
        summarize();
    end
endmodule
`default_nettype wire
